/* bench/banked_data_memory_decoder_test.sv */
// self-checking bench for the banked data memory decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("unexpected %0t %h %h", $time, a, b); end end
module banked_data_memory_decoder_test;
    import dmem_pkg::*;
    logic       clk_i = 0, rstn_i = 0, wr_i, rd_i, flags_we_i;
    logic [6:0] addr_i;
    logic [4:0] flags_i;
    logic [7:0] wdata_i, rdata_o, status_o, pointer_o, d;
    logic [1:0] bank_o;
    int         fails = 0, num_checks = 0;
    always #5 clk_i = ~clk_i;
    core_model u_core_model (.clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
        .rd_o(rd_i), .flags_we_o(flags_we_i), .flags_o(flags_i));
    banked_data_memory_decoder u_banked_data_memory_decoder (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .flags_i, .flags_we_i, .rdata_o, .status_o, .pointer_o, .bank_o);
    task conclude;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task sel(input logic [1:0] b);
        u_core_model.put(OFS_STATUS, {1'b0, b, 5'h18});
        `CHK(bank_o, b)
    endtask : sel
    task t_banks;
        for (int b = 0; b < 4; b++) begin sel(2'(b)); u_core_model.put(7'h20, 8'(8'h40 + b)); end
        for (int b = 0; b < 4; b++) begin
            sel(2'(b));
            u_core_model.get(7'h20, d);
            `CHK(d, (b == 3) ? 8'h00 : 8'(8'h40 + b))
        end
        u_core_model.put(7'h7f, 8'h77);
        sel(0);
        u_core_model.get(7'h7f, d); `CHK(d, 8'h77)
        u_core_model.put(7'h6f, 8'h3c);
        u_core_model.get(7'h6f, d); `CHK(d, 8'h3c)
        $display("banks done");
    endtask : t_banks
    task t_ind;
        sel(2);
        u_core_model.put(OFS_POINTER, 8'ha0); `CHK(pointer_o, 8'ha0)
        u_core_model.get(OFS_INDIRECT, d); `CHK(d, 8'h41)
        u_core_model.put(OFS_POINTER, 8'h21);
        u_core_model.put(OFS_INDIRECT, 8'h5a);
        sel(0);
        u_core_model.get(7'h21, d); `CHK(d, 8'h5a)
        u_core_model.get(OFS_STATUS, d); `CHK(d[6:5], 2'h0)
        $display("indirect done");
    endtask : t_ind
    task t_zero;
        sel(1);
        u_core_model.put(7'h05, 8'hff);
        u_core_model.get(7'h05, d); `CHK(d, 8'h00)
        u_core_model.get(7'h02, d); `CHK(d, 8'h00)
        u_core_model.put(OFS_POINTER, 8'h00);
        u_core_model.get(OFS_INDIRECT, d); `CHK(d, 8'h00)
        u_core_model.upd(5'h07);
        `CHK(status_o, 8'h27)
        `CHK(bank_o, 2'h1)
        $display("zero done");
    endtask : t_zero
    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1 `CHK(pointer_o, POINTER_RESET)
        t_banks;
        t_ind;
        t_zero;
        conclude;
    end
    // whole run is well under 200 cycles
    initial begin
        #20000;
        fails++;
        conclude;
    end
endmodule : banked_data_memory_decoder_test
`default_nettype wire

/* bench/core_model.sv */
// processor core model driving the data memory port
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [6:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o, rd_o, flags_we_o,
    output logic      [4:0] flags_o
);
    initial {addr_o, wdata_o, wr_o, rd_o, flags_we_o, flags_o} = '0;
    // released data inverted so a stale byte never looks valid
    task put(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i) {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
        @(posedge clk_i) {wdata_o, wr_o} <= {~d, 1'b0};
        #1;
    endtask : put
    // core flag update drives only the low status bits
    task upd(input logic [4:0] f);
        @(posedge clk_i) {flags_o, flags_we_o} <= {f, 1'b1};
        @(posedge clk_i) flags_we_o <= 1'b0;
        #1;
    endtask : upd
    task get(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i) {addr_o, rd_o} <= {a, 1'b1};
        @(posedge clk_i) rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask : get
endmodule : core_model
`default_nettype wire

/* bench/dmem_checker.sv */
// port assertions for the banked data memory decoder
`timescale 1ns/1ps
`default_nettype none
module dmem_checker (
    input wire logic       clk_i, rstn_i, wr_i, rd_i, flags_we_i,
    input wire logic [6:0] addr_i,
    input wire logic [4:0] flags_i,
    input wire logic [7:0] wdata_i, rdata_o, status_o, pointer_o,
    input wire logic [1:0] bank_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    bank_field_a: assert property (bank_o == status_o[6:5]) else $error("bank off");
    status_bank_a: assert property (wr_i && addr_i == 7'h03 |=>
        status_o[6:5] == $past(wdata_i[6:5])) else $error("bank write lost");
    pointer_wr_a: assert property (wr_i && addr_i == 7'h04 |=> pointer_o == $past(wdata_i)) else $error("ptr");
    status_rd_a: assert property (rd_i && addr_i == 7'h03 |=> rdata_o == $past(status_o)) else $error("st");
    read_hold_a: assert property (!rd_i |=> $stable(rdata_o)) else $error("read data moved");
    sfr_gap_a: assert property (rd_i && addr_i > 7'h04 && addr_i < 7'h20 |=> rdata_o == 8'h00) else $error("gap");
    sfr_low_a: assert property (rd_i && addr_i inside {7'h01, 7'h02} |=> rdata_o == 8'h00) else $error("low");
    bank3_gap_a: assert property (rd_i && bank_o == 2'h3 && addr_i >= 7'h20 && addr_i < 7'h70
        |=> rdata_o == 8'h00) else $error("bank3 storage");
endmodule : dmem_checker
bind banked_data_memory_decoder dmem_checker u_dmem_checker (.clk_i, .rstn_i, .wr_i, .rd_i, .flags_we_i,
    .addr_i, .flags_i, .wdata_i, .rdata_o, .status_o, .pointer_o, .bank_o);
`default_nettype wire

/* design/banked_data_memory_decoder.sv */
// banked data memory decoder with core registers and general purpose storage
// How it works
// - bank from status bits 6:5 plus offset
// - each bank spans seven-bit offsets 0..7Fh
// - special registers sit at low offsets
// - upper offsets are general purpose storage, in bank 3 only 70h..7Fh
// - core registers answer in every bank
// - storage reached directly, or via pointer in banks 0 and 1 only
// - offset zero redirects through the pointer
// - unimplemented locations read zero, hold nothing
// - data port independent of program fetch
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_decoder
    import dmem_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [OFS_W-1:0] addr_i,
    input  wire logic [DAT_W-1:0] wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    input  wire logic [4:0]       flags_i,
    input  wire logic             flags_we_i,
    output logic      [DAT_W-1:0] rdata_o,
    output logic      [DAT_W-1:0] status_o,
    output logic      [DAT_W-1:0] pointer_o,
    output logic      [BANK_W-1:0] bank_o
);
    logic [DAT_W-1:0] status_reg;
    logic [DAT_W-1:0] status_next;
    logic [DAT_W-1:0] pointer_reg;
    logic [DAT_W-1:0] rdata_reg;

    // own data port, never shared with program fetch, so no stall exists
    wire              indirect_hit = (addr_i == OFS_INDIRECT);
    wire [BANK_W-1:0] bank_sel     = status_reg[BANK_SEL_HI:BANK_SEL_LO];
    // pointer supplies bank1 bit and offset; the high bank bit comes from the unused flag, zero here
    wire [ADDR_W-1:0] ind_addr     = {IRP_ZERO, pointer_reg};
    wire [ADDR_W-1:0] dir_addr     = {bank_sel, addr_i};
    wire [ADDR_W-1:0] eff_addr     = indirect_hit ? ind_addr : dir_addr;
    wire [BANK_W-1:0] eff_bank     = eff_addr[ADDR_W-1:OFS_W];
    wire [OFS_W-1:0]  eff_ofs      = eff_addr[OFS_W-1:0];

    // core registers mirror across all banks; indirect via offset 0 reads zero
    wire              sel_status   = (eff_ofs == OFS_STATUS);
    wire              sel_pointer  = (eff_ofs == OFS_POINTER);
    wire              sel_indir    = (eff_ofs == OFS_INDIRECT);
    wire              in_common    = (eff_ofs >= OFS_COMMON_LO);
    wire              in_b0_gpr    = (eff_bank == BANK0) && (eff_ofs >= OFS_GPR0_LO);
    wire              in_bn_gpr    = ((eff_bank == BANK1) || (eff_bank == BANK2))
                                     && (eff_ofs >= OFS_GPRN_LO);
    wire              gpr_hit      = in_common || in_b0_gpr || in_bn_gpr;
    wire [7:0]        ofs8         = {1'b0, eff_ofs};
    wire [7:0]        rel0         = ofs8 - {1'b0, OFS_GPR0_LO};
    wire [7:0]        reln         = ofs8 - {1'b0, OFS_GPRN_LO};
    wire [7:0]        rel_common   = ofs8 - {1'b0, OFS_COMMON_LO};
    wire [GPR_IDX_W-1:0] gpr_idx   = in_common ? (SLOT_COMMON + rel_common) :
                                     (eff_bank == BANK0) ? rel0 :
                                     (eff_bank == BANK1) ? (SLOT_BANK1 + reln) :
                                     (SLOT_BANK2 + reln);
    wire              gpr_we       = wr_i && gpr_hit && !sel_indir;
    wire [DAT_W-1:0]  gpr_rdata;

    wire [DAT_W-1:0]  rd_mux       = sel_indir   ? READ_ZERO :
                                     sel_status  ? status_reg :
                                     sel_pointer ? pointer_reg :
                                     gpr_hit     ? gpr_rdata : READ_ZERO;

    gpr_store u_gpr (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .we_i    (gpr_we),
        .idx_i   (gpr_idx),
        .wdata_i (wdata_i),
        .rdata_o (gpr_rdata)
    );

    // software write of status wins over the core flag update in the same cycle
    always_comb begin
        status_next = status_reg;
        if (flags_we_i)
            status_next[4:0] = flags_i;
        if (wr_i && sel_status)
            status_next = wdata_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg  <= STATUS_RESET;
            pointer_reg <= POINTER_RESET;
            rdata_reg   <= READ_ZERO;
        end else begin
            status_reg <= status_next;
            if (wr_i && sel_pointer)
                pointer_reg <= wdata_i;
            if (rd_i)
                rdata_reg <= rd_mux;
        end
    end

    assign rdata_o   = rdata_reg;
    assign status_o  = status_reg;
    assign pointer_o = pointer_reg;
    assign bank_o    = status_reg[BANK_SEL_HI:BANK_SEL_LO];
endmodule : banked_data_memory_decoder
`default_nettype wire

/* design/dmem_pkg.sv */
// constants for the banked data memory decoder
package dmem_pkg;
    localparam int          OFS_W          = 7;
    localparam int          DAT_W          = 8;
    localparam int          ADDR_W         = 9;
    localparam int          BANK_W         = 2;
    localparam int          GPR_DEPTH      = 256;
    localparam int          GPR_IDX_W      = 8;
    // status register layout
    localparam int          BANK_SEL_HI    = 6;
    localparam int          BANK_SEL_LO    = 5;
    // core register offsets, mirrored in every bank
    localparam logic [6:0]  OFS_INDIRECT   = 7'h00;
    localparam logic [6:0]  OFS_STATUS     = 7'h03;
    localparam logic [6:0]  OFS_POINTER    = 7'h04;
    // general purpose windows
    localparam logic [6:0]  OFS_GPR0_LO    = 7'h20;
    localparam logic [6:0]  OFS_GPRN_LO    = 7'h20;
    localparam logic [6:0]  OFS_COMMON_LO  = 7'h70;
    localparam logic [6:0]  OFS_TOP        = 7'h7f;
    localparam logic [7:0]  STATUS_RESET   = 8'h18;
    localparam logic [7:0]  POINTER_RESET  = 8'h00;
    localparam logic [7:0]  READ_ZERO      = 8'h00;
    localparam logic [1:0]  BANK0          = 2'h0;
    localparam logic [1:0]  BANK1          = 2'h1;
    localparam logic [1:0]  BANK2          = 2'h2;
    localparam logic [1:0]  BANK3          = 2'h3;
    // storage slot bases: bank0 96 bytes, bank1 80, bank2 80 (common area in bank0 slots)
    localparam logic [7:0]  SLOT_BANK1     = 8'h60;
    localparam logic [7:0]  SLOT_BANK2     = 8'hb0;
    localparam logic [7:0]  SLOT_COMMON    = 8'h50;
    localparam logic        IRP_ZERO       = 1'b0;
endpackage : dmem_pkg

/* design/gpr_store.sv */
// flip-flop storage for the general purpose registers
`timescale 1ns/1ps
`default_nettype none
module gpr_store
    import dmem_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 we_i,
    input  wire logic [GPR_IDX_W-1:0] idx_i,
    input  wire logic [DAT_W-1:0]     wdata_i,
    output logic      [DAT_W-1:0]     rdata_o
);
    logic [DAT_W-1:0] mem_reg [GPR_DEPTH];

    genvar i;
    generate
        for (i = 0; i < GPR_DEPTH; i++) begin : g_cell
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i)
                    mem_reg[i] <= READ_ZERO;
                else if (we_i && idx_i == GPR_IDX_W'(i))
                    mem_reg[i] <= wdata_i;
            end
        end
    endgenerate

    assign rdata_o = mem_reg[idx_i];
endmodule : gpr_store
`default_nettype wire
